// [counter4_pkg.sv]
package counter4_pkg;

	// register byte offsets, decoded on haddr[7:0]
	localparam int addr_bits = 8;
	localparam logic [7:0] ctrl_offset = 8'h00;
	localparam logic [7:0] step_offset = 8'h04;
	localparam logic [7:0] status_offset = 8'h08;

	// control word field positions
	localparam int ctrl_up_pos = 0;
	localparam int ctrl_load_pos = 1;
	localparam int ctrl_pcen_pos = 2;
	localparam int ctrl_ccen_pos = 3;
	localparam int ctrl_free_pos = 4;
	localparam int ctrl_preset_lsb = 8;

	// status word field positions
	localparam int status_count_lsb = 0;
	localparam int status_tc_pos = 4;

	localparam logic [31:0] ctrl_reset_value = 32'h0000000f;
	localparam logic [3:0] count_reset_value = 4'h0;
	localparam logic [3:0] count_top = 4'hf;
	localparam logic [3:0] count_bottom = 4'h0;
	localparam logic [3:0] count_one = 4'h1;
	localparam logic [31:0] read_zero = 32'h00000000;
	localparam logic hresp_okay = 1'b0;

	typedef struct packed {
		logic [3:0] preset_value;
		logic free_run;
		logic carry_count_enable_n;
		logic parallel_count_enable_n;
		logic load_enable_n;
		logic count_up;
	} ctrl_t;

	// gray along idle -> read_wait -> read_done -> write -> idle
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_read_wait = 2'b01,
		st_read_done = 2'b11,
		st_write = 2'b10
	} bus_state_t;

endpackage

// [counter_core.sv]
`timescale 1ns/100ps
module counter_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic count_edge,
	input wire counter4_pkg::ctrl_t ctrl,
	input wire counter4_pkg::ctrl_t ctrl_next,
	output logic [3:0] count_value,
	output logic terminal_flag_n
);
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic tc_reg;
	logic tc_next;
	logic [3:0] stepped;
	logic [3:0] term_next;
	logic load_now;
	logic count_now;

	assign load_now = !ctrl.load_enable_n;
	assign count_now = !ctrl.parallel_count_enable_n && !ctrl.carry_count_enable_n;
	// modulo-16 wrap falls out of the 4-bit width
	assign stepped = ctrl.count_up ? 4'(count_reg + counter4_pkg::count_one)
		: 4'(count_reg - counter4_pkg::count_one);
	assign count_next = !count_edge ? count_reg
		: load_now ? ctrl.preset_value
		: count_now ? stepped : count_reg;

	// flag is computed from next-state values so the flop always matches
	// the present count and carry enable: no extra edge of lag
	assign term_next = ctrl_next.count_up ? counter4_pkg::count_top : counter4_pkg::count_bottom;
	assign tc_next = !(!ctrl_next.carry_count_enable_n && (count_next == term_next));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= counter4_pkg::count_reset_value;
			tc_reg <= 1'b1;
		end else begin
			count_reg <= count_next;
			tc_reg <= tc_next;
		end
	end

	assign count_value = count_reg;
	assign terminal_flag_n = tc_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_load;
		count_edge && !ctrl.load_enable_n |=> count_value == $past(ctrl.preset_value);
	endproperty
	a_load: assert property (p_load) else $error("load did not copy preset");

	property p_count_up;
		count_edge && ctrl.load_enable_n && count_now && ctrl.count_up
			|=> count_value == 4'($past(count_value) + 4'h1);
	endproperty
	a_count_up: assert property (p_count_up) else $error("count up wrong");

	property p_count_down;
		count_edge && ctrl.load_enable_n && count_now && !ctrl.count_up
			|=> count_value == 4'($past(count_value) - 4'h1);
	endproperty
	a_count_down: assert property (p_count_down) else $error("count down wrong");

	property p_hold;
		count_edge && ctrl.load_enable_n && !count_now |=> $stable(count_value);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while disabled");

	property p_no_edge;
		!count_edge |=> $stable(count_value);
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("count moved without edge");

	property p_wrap;
		count_edge && ctrl.load_enable_n && count_now && ctrl.count_up && count_value == 4'hf
			|=> count_value == 4'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap from fifteen to zero");

	property p_tc_low;
		!ctrl.carry_count_enable_n && count_value == (ctrl.count_up ? 4'hf : 4'h0) |-> !terminal_flag_n;
	endproperty
	a_tc_low: assert property (p_tc_low) else $error("terminal flag not low");

	property p_tc_high;
		ctrl.carry_count_enable_n || count_value != (ctrl.count_up ? 4'hf : 4'h0) |-> terminal_flag_n;
	endproperty
	a_tc_high: assert property (p_tc_high) else $error("terminal flag not high");
endmodule

// [presettable_updown_counter4.sv]
`timescale 1ns/100ps
// How it works
// - four-bit count, wraps at 16, clocked changes
// - load low copies preset, beats everything
// - both enables low: direction picks up/down
// - either enable high holds count
// - flag low: carry enable low, at terminal
// - terminal is ones up, zeros down
// - carry enable gates flag without extra edge
// - from twelve: 13, 14, 15, 0, up
module presettable_updown_counter4 (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [3:0] count_value,
	output logic terminal_flag_n
);
	counter4_pkg::bus_state_t state_reg;
	counter4_pkg::bus_state_t state_next;
	logic [7:0] addr_reg;
	logic [7:0] addr_next;
	counter4_pkg::ctrl_t ctrl_reg;
	counter4_pkg::ctrl_t ctrl_next;
	counter4_pkg::ctrl_t ctrl_written;
	logic hreadyout_reg;
	logic hresp_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] read_word;
	logic addr_phase;
	logic hit_ctrl;
	logic hit_step;
	logic hit_status;
	logic wr_ctrl;
	logic wr_step;
	logic count_edge;
	logic [3:0] core_count;
	logic core_tc_n;

	// only single word transfers are expected; hsize is not checked
	assign addr_phase = hsel && hready && htrans[1];

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			counter4_pkg::st_idle,
			counter4_pkg::st_write,
			counter4_pkg::st_read_done: begin
				if (addr_phase) begin
					state_next = hwrite ? counter4_pkg::st_write : counter4_pkg::st_read_wait;
				end else begin
					state_next = counter4_pkg::st_idle;
				end
			end
			// one wait state so a read sees the result of a write just before
			counter4_pkg::st_read_wait: begin
				state_next = counter4_pkg::st_read_done;
			end
			default: begin
				state_next = counter4_pkg::st_idle;
			end
		endcase
	end

	assign addr_next = addr_phase ? haddr[counter4_pkg::addr_bits-1:0] : addr_reg;
	assign hit_ctrl = addr_reg == counter4_pkg::ctrl_offset;
	assign hit_step = addr_reg == counter4_pkg::step_offset;
	assign hit_status = addr_reg == counter4_pkg::status_offset;
	assign wr_ctrl = state_reg == counter4_pkg::st_write && hit_ctrl;
	assign wr_step = state_reg == counter4_pkg::st_write && hit_step;

	always_comb begin
		ctrl_written.count_up = hwdata[counter4_pkg::ctrl_up_pos];
		ctrl_written.load_enable_n = hwdata[counter4_pkg::ctrl_load_pos];
		ctrl_written.parallel_count_enable_n = hwdata[counter4_pkg::ctrl_pcen_pos];
		ctrl_written.carry_count_enable_n = hwdata[counter4_pkg::ctrl_ccen_pos];
		ctrl_written.free_run = hwdata[counter4_pkg::ctrl_free_pos];
		ctrl_written.preset_value = hwdata[counter4_pkg::ctrl_preset_lsb +: 4];
	end

	assign ctrl_next = wr_ctrl ? ctrl_written : ctrl_reg;

	// a step write is one rising edge of the count clock; free run steps
	// on every hclk edge, which makes the count rate fixed at hclk
	assign count_edge = wr_step || ctrl_reg.free_run;

	always_comb begin
		ctrl_word = counter4_pkg::read_zero;
		ctrl_word[counter4_pkg::ctrl_up_pos] = ctrl_reg.count_up;
		ctrl_word[counter4_pkg::ctrl_load_pos] = ctrl_reg.load_enable_n;
		ctrl_word[counter4_pkg::ctrl_pcen_pos] = ctrl_reg.parallel_count_enable_n;
		ctrl_word[counter4_pkg::ctrl_ccen_pos] = ctrl_reg.carry_count_enable_n;
		ctrl_word[counter4_pkg::ctrl_free_pos] = ctrl_reg.free_run;
		ctrl_word[counter4_pkg::ctrl_preset_lsb +: 4] = ctrl_reg.preset_value;
	end

	always_comb begin
		status_word = counter4_pkg::read_zero;
		status_word[counter4_pkg::status_count_lsb +: 4] = core_count;
		status_word[counter4_pkg::status_tc_pos] = core_tc_n;
	end

	assign read_word = hit_ctrl ? ctrl_word : hit_status ? status_word : counter4_pkg::read_zero;
	assign hrdata_next = state_reg == counter4_pkg::st_read_wait ? read_word : hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= counter4_pkg::st_idle;
			addr_reg <= counter4_pkg::ctrl_offset;
			ctrl_reg <= counter4_pkg::ctrl_t'(counter4_pkg::ctrl_reset_value[8:0]);
			hreadyout_reg <= 1'b1;
			hresp_reg <= counter4_pkg::hresp_okay;
			hrdata_reg <= counter4_pkg::read_zero;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			ctrl_reg <= ctrl_next;
			hreadyout_reg <= state_next != counter4_pkg::st_read_wait;
			hresp_reg <= counter4_pkg::hresp_okay;
			hrdata_reg <= hrdata_next;
		end
	end

	counter_core u_core (
		.hclk(hclk),
		.hresetn(hresetn),
		.count_edge(count_edge),
		.ctrl(ctrl_reg),
		.ctrl_next(ctrl_next),
		.count_value(core_count),
		.terminal_flag_n(core_tc_n)
	);

	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign hrdata = hrdata_reg;
	assign count_value = core_count;
	assign terminal_flag_n = core_tc_n;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_read_wait;
		addr_phase && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

	property p_write_ctrl;
		wr_ctrl |=> ctrl_reg.count_up == $past(hwdata[0]) && ctrl_reg.preset_value == $past(hwdata[11:8]);
	endproperty
	a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");

	property p_read_status;
		state_reg == counter4_pkg::st_read_wait && hit_status
			|=> hrdata[3:0] == $past(core_count) && hrdata[4] == $past(core_tc_n) && hrdata[31:5] == 27'h0;
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read wrong");

	property p_step_once;
		wr_step && !ctrl_reg.free_run && ctrl_reg.load_enable_n && ctrl_reg.count_up
			&& !ctrl_reg.parallel_count_enable_n && !ctrl_reg.carry_count_enable_n
			##1 !count_edge |=> $stable(core_count);
	endproperty
	a_step_once: assert property (p_step_once) else $error("step gave more than one edge");

	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");

	property p_write_ready;
		addr_phase && hwrite |=> hreadyout;
	endproperty
	a_write_ready: assert property (p_write_ready) else $error("write inserted a wait state");

	property p_hrdata_hold;
		state_reg != counter4_pkg::st_read_wait |=> $stable(hrdata);
	endproperty
	a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved outside a read");

	property p_read_ctrl;
		state_reg == counter4_pkg::st_read_wait && hit_ctrl
			|=> hrdata[0] == $past(ctrl_reg.count_up) && hrdata[4] == $past(ctrl_reg.free_run)
			&& hrdata[11:8] == $past(ctrl_reg.preset_value) && hrdata[31:12] == 20'h0;
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

	property p_read_unmapped;
		state_reg == counter4_pkg::st_read_wait && !hit_ctrl && !hit_status |=> hrdata == 32'h0;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

	// free run counts on every hclk edge, not only on step writes
	property p_free_up;
		ctrl_reg.free_run && ctrl_reg.load_enable_n && ctrl_reg.count_up
			&& !ctrl_reg.parallel_count_enable_n && !ctrl_reg.carry_count_enable_n
			|=> core_count == 4'($past(core_count) + 4'h1);
	endproperty
	a_free_up: assert property (p_free_up) else $error("free run did not count up");
endmodule

// [ahb_master_model.sv]
`timescale 1ns/100ps
module ahb_master_model (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	logic hung;
	initial begin
		hung = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	task automatic wait_ready();
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && i < 20) begin
			@(posedge hclk);
			i++;
		end
		if (hready !== 1'b1)
			hung = 1'b1;
	endtask
	// entered just after a rising edge; single word transfers only
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		hsize <= 3'h2;
		// data bus outside its phase must not look valid
		hwdata <= ~hwdata;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
endmodule

// [presettable_updown_counter4_tb_top.sv]
`timescale 1ns/100ps
module presettable_updown_counter4_tb_top;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [4:0] steps;
		logic [3:0] cnt;
		logic flag;
	} row_t;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [3:0] count_value;
	logic terminal_flag_n;
	logic [31:0] rd;
	logic cascade_on = 1'b0;
	logic [3:0] upper_count;
	logic [3:0] wrap_count;
	logic [3:0] last_count;
	int errors = 0;
	int n_compared = 0;
	row_t rows [11] = '{
		{32'h00000c0d, 5'h01, 4'hc, 1'b1},
		{32'h00000003, 5'h03, 4'hf, 1'b0},
		{32'h0000000b, 5'h00, 4'hf, 1'b1},
		{32'h00000003, 5'h00, 4'hf, 1'b0},
		{32'h00000002, 5'h00, 4'hf, 1'b1},
		{32'h00000003, 5'h01, 4'h0, 1'b1},
		{32'h00000002, 5'h01, 4'hf, 1'b1},
		{32'h00000002, 5'h0f, 4'h0, 1'b0},
		{32'h00000006, 5'h02, 4'h0, 1'b0},
		{32'h0000000a, 5'h02, 4'h0, 1'b1},
		{32'h00000500, 5'h01, 4'h5, 1'b1}
	};
	presettable_updown_counter4 u_dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.count_value(count_value),
		.terminal_flag_n(terminal_flag_n)
	);
	ahb_master_model u_master (
		.hclk(hclk),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata)
	);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// next stage on the same clock, its carry enable fed by our terminal flag;
	// only meaningful in free run, where every hclk edge is a count edge
	always @(posedge hclk) begin
		if (!cascade_on) begin
			upper_count <= 4'h0;
			wrap_count <= 4'h0;
		end else begin
			if (terminal_flag_n == 1'b0) begin
				upper_count <= 4'(upper_count + 4'h1);
			end
			if (last_count == 4'hf && count_value == 4'h0) begin
				wrap_count <= 4'(wrap_count + 4'h1);
			end
		end
		last_count <= count_value;
	end
	task automatic stop_test();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		u_master.xfer(wr, a, wd, rd);
		if (u_master.hung === 1'b1) begin
			errors++;
			$display("unexpected at %0t: bus wait ran out", $time);
			stop_test();
		end
	endtask
	task automatic chk_word(input logic [31:0] exp);
		n_compared++;
		if (rd !== exp) begin
			errors++;
			$display("unexpected at %0t: read %h, wanted %h", $time, rd, exp);
		end
	endtask
	// samples at the falling edge so the counting edge has landed
	task automatic chk_port(input logic [3:0] cnt, input logic flag);
		@(negedge hclk);
		n_compared++;
		if (count_value !== cnt || terminal_flag_n !== flag) begin
			errors++;
			$display("unexpected at %0t: count %h flag %b", $time, count_value, terminal_flag_n);
		end
		@(posedge hclk);
	endtask
	task automatic chk_cascade(input logic [3:0] wraps);
		n_compared++;
		if (upper_count !== wraps || wrap_count !== wraps) begin
			errors++;
			$display("unexpected at %0t: upper %h wraps %h, wanted %h", $time, upper_count, wrap_count, wraps);
		end
	endtask
	initial begin
		hresetn = 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		chk_port(counter4_pkg::count_reset_value, 1'b1);
		bus(1'b0, counter4_pkg::ctrl_offset, 32'h0);
		chk_word(counter4_pkg::ctrl_reset_value);
		bus(1'b0, 8'h10, 32'h0);
		chk_word(counter4_pkg::read_zero);
		bus(1'b0, counter4_pkg::step_offset, 32'h0);
		chk_word(counter4_pkg::read_zero);
		for (int i = 0; i < 11; i++) begin
			bus(1'b1, counter4_pkg::ctrl_offset, rows[i].ctrl);
			for (int s = 0; s < rows[i].steps; s++)
				bus(1'b1, counter4_pkg::step_offset, 32'h0);
			chk_port(rows[i].cnt, rows[i].flag);
			bus(1'b0, counter4_pkg::status_offset, 32'h0);
			chk_word({27'h0, rows[i].flag, rows[i].cnt});
			bus(1'b0, counter4_pkg::ctrl_offset, 32'h0);
			chk_word(rows[i].ctrl);
		end
		// free run up from 5 over 42 edges: two wraps, stops at 15
		cascade_on <= 1'b1;
		bus(1'b1, counter4_pkg::ctrl_offset, 32'h00000013);
		repeat (40) @(posedge hclk);
		bus(1'b1, counter4_pkg::ctrl_offset, counter4_pkg::ctrl_reset_value);
		chk_port(4'hf, 1'b1);
		chk_cascade(4'h2);
		cascade_on <= 1'b0;
		// reset after the free run must clear the count of 15
		hresetn <= 1'b0;
		chk_port(counter4_pkg::count_reset_value, 1'b1);
		hresetn <= 1'b1;
		// enables come back high from reset, so a step must hold
		bus(1'b1, counter4_pkg::step_offset, 32'h0);
		chk_port(counter4_pkg::count_reset_value, 1'b1);
		bus(1'b0, counter4_pkg::ctrl_offset, 32'h0);
		chk_word(counter4_pkg::ctrl_reset_value);
		stop_test();
	end
endmodule
